// ---- shared/pulse_counter_map.svh ----
// Register offsets, field positions, reset values and timing counts of the pulse counters
`ifndef PULSE_COUNTER_MAP_SVH
`define PULSE_COUNTER_MAP_SVH

// Word addresses on the Avalon bus; each register one 32-bit word
// Bus address equals register offset, so the 8-bit address reaches every register
`define PC_ADDR_WIDTH 8
`define PC_CONTROL_IDX 8'h40
`define PC_CNT1_LO_IDX 8'h41
`define PC_CNT1_HI_IDX 8'h42
`define PC_CNT2_LO_IDX 8'h43
`define PC_CNT2_HI_IDX 8'h44
`define PC_IRQ_STATUS_IDX 8'h45
`define PC_IRQ_MASK_IDX 8'h46
`define PC_CONTROL_ADDR `PC_CONTROL_IDX
`define PC_CNT1_LO_ADDR `PC_CNT1_LO_IDX
`define PC_CNT1_HI_ADDR `PC_CNT1_HI_IDX
`define PC_CNT2_LO_ADDR `PC_CNT2_LO_IDX
`define PC_CNT2_HI_ADDR `PC_CNT2_HI_IDX
`define PC_IRQ_STATUS_ADDR `PC_IRQ_STATUS_IDX
`define PC_IRQ_MASK_ADDR `PC_IRQ_MASK_IDX

// Control register fields
`define PC_BIT_ENABLE_ONE 7
`define PC_BIT_IRQ_EN_ONE 6
`define PC_BIT_FLAG_ONE 4
`define PC_BIT_ENABLE_TWO 3
`define PC_BIT_IRQ_EN_TWO 2
`define PC_BIT_FLAG_TWO 0
`define PC_CONTROL_RW_MASK 8'hDD
`define PC_CONTROL_RESET 8'h00
`define PC_COUNTER_RESET 16'h0000
`define PC_COUNTER_MAX 16'hFFFF

// Interrupt status/mask fields: bit 0 overflow one, bit 1 overflow two
`define PC_IRQ_BITS 2
`define PC_IRQ_RESET 2'h0

// Timing: input rate limit and read-window pulse figure
`define PC_CLK_MHZ 100
`define PC_MAX_RATE_MHZ 1
`define PC_MIN_PERIOD_CYCLES (`PC_CLK_MHZ / `PC_MAX_RATE_MHZ)
`define PC_READ_EXTRA_NS 500
`define PC_READ_EXTRA_CYCLES ((`PC_READ_EXTRA_NS * `PC_CLK_MHZ + 999) / 1000)

`endif

// ---- shared/pulse_counter_pkg.sv ----
// Types shared by the pulse counter design
package pulse_counter_pkg;
	typedef struct packed {
		logic write;
		logic read;
		logic [7:0] byte_addr;
		logic [31:0] wdata;
	} bus_req_type;

	typedef struct packed {
		logic load_lo;
		logic load_hi;
		logic [7:0] wdata;
		logic enable;
	} counter_ctl_type;

	typedef enum logic [1:0] {
		BUS_IDLE = 2'b00,
		BUS_ANSWER = 2'b01,
		BUS_RELEASE = 2'b11
	} bus_state_type;
endpackage

// ---- hdl/pulse_counter_unit.sv ----
// One 16-bit pulse counter with edge detect, byte load and overflow pulse
`timescale 1ns/1ps
`include "pulse_counter_map.svh"
module pulse_counter_unit
	import pulse_counter_pkg::*;
(
	input wire logic core_clk_in, // System clock
	input wire logic reset_n_in, // Synchronous reset, active low
	input wire logic pulse_in, // Synchronised count input
	input wire counter_ctl_type ctl_in, // Enable and byte loads
	output logic [15:0] count_out, // Current count
	output logic overflow_out // One-cycle pulse on roll-over while armed
);
	typedef struct packed {
		logic last;
		logic [15:0] count;
		logic armed;
		logic overflow;
	} unit_state_type;

	unit_state_type s_r;
	unit_state_type s_nxt;

	always_comb begin
		s_nxt = s_r;
		s_nxt.last = pulse_in;
		s_nxt.overflow = 1'b0;
		if (ctl_in.load_lo || ctl_in.load_hi) begin
			// Write wins over a coinciding edge; that event is lost
			if (ctl_in.load_lo) begin
				s_nxt.count[7:0] = ctl_in.wdata;
			end
			if (ctl_in.load_hi) begin
				s_nxt.count[15:8] = ctl_in.wdata;
			end
			// Loads keep the arm state: zero by roll-over or reset stays disarmed
		end else if (ctl_in.enable && s_r.last && !pulse_in) begin
			s_nxt.count = s_r.count + 16'h0001;
			// A wrap disarms, any other count arms
			s_nxt.armed = (s_r.count != `PC_COUNTER_MAX);
			if (s_r.count == `PC_COUNTER_MAX) begin
				s_nxt.overflow = s_r.armed;
			end
		end
	end

	always_ff @(posedge core_clk_in) begin
		if (!reset_n_in) begin
			s_r <= '{last: 1'b0, count: `PC_COUNTER_RESET, armed: 1'b0, overflow: 1'b0};
		end else begin
			s_r <= s_nxt;
		end
	end

	assign count_out = s_r.count;
	assign overflow_out = s_r.overflow;
endmodule

// ---- hdl/dual_pulse_counter.sv ----
// Two 16-bit falling-edge pulse counters with control register and Avalon-MM slave
//
// The implementer's own choice: the Avalon-MM register port.
`timescale 1ns/1ps
`include "pulse_counter_map.svh"
module dual_pulse_counter
	import pulse_counter_pkg::*;
(
	input wire logic core_clk_in, // 100 MHz system clock
	input wire logic reset_n_in, // Synchronous reset, active low
	input wire logic pulse_input_one_in, // Count input one, async pin
	input wire logic pulse_input_two_in, // Count input two, async pin
	input wire logic [7:0] avs_address_in, // Word address, one per register
	input wire logic avs_read_in, // Read request
	input wire logic avs_write_in, // Write request
	input wire logic [31:0] avs_writedata_in, // Write data
	input wire logic [3:0] avs_byteenable_in, // Byte enables
	output logic [31:0] avs_readdata_out, // Read data
	output logic avs_waitrequest_out, // Stall until answer
	output logic [1:0] avs_response_out, // 00 okay, 10 slave error
	output logic external_interrupt_line_out, // Overflow request line, active high
	output logic irq_out // Masked level interrupt
);
	// ==========================================================
	// State
	typedef struct packed {
		logic [1:0] sync_one;
		logic [1:0] sync_two;
		logic [7:0] control;
		logic [1:0] irq_status;
		logic [1:0] irq_mask;
		bus_state_type bus_state;
		logic [31:0] readdata;
		logic [1:0] response;
		logic waitrequest;
		logic ext_line;
		logic irq;
	} top_state_type;

	top_state_type s_r;
	top_state_type s_nxt;
	bus_req_type req;
	counter_ctl_type ctl_one;
	counter_ctl_type ctl_two;
	logic [15:0] count_one;
	logic [15:0] count_two;
	logic ovf_one;
	logic ovf_two;
	logic take;
	logic wr_lane0;
	logic [7:0] wbyte;

	// ==========================================================
	// Request decode
	always_comb begin
		req.write = avs_write_in;
		req.read = avs_read_in;
		req.byte_addr = avs_address_in;
		req.wdata = avs_writedata_in;
	end

	// A write is acted on once, at the edge that ends the cycle with waitrequest low
	assign take = (s_r.bus_state == BUS_ANSWER);
	assign wr_lane0 = take && req.write && avs_byteenable_in[0];
	assign wbyte = req.wdata[7:0];

	always_comb begin
		ctl_one = '0;
		ctl_two = '0;
		ctl_one.enable = s_r.control[`PC_BIT_ENABLE_ONE];
		ctl_two.enable = s_r.control[`PC_BIT_ENABLE_TWO];
		ctl_one.wdata = wbyte;
		ctl_two.wdata = wbyte;
		ctl_one.load_lo = wr_lane0 && (req.byte_addr == 8'(`PC_CNT1_LO_ADDR));
		ctl_one.load_hi = wr_lane0 && (req.byte_addr == 8'(`PC_CNT1_HI_ADDR));
		ctl_two.load_lo = wr_lane0 && (req.byte_addr == 8'(`PC_CNT2_LO_ADDR));
		ctl_two.load_hi = wr_lane0 && (req.byte_addr == 8'(`PC_CNT2_HI_ADDR));
	end

	// ==========================================================
	// Counters; reads never stall counting, so no event is lost then
	pulse_counter_unit counter_one (
		.core_clk_in(core_clk_in),
		.reset_n_in(reset_n_in),
		.pulse_in(s_r.sync_one[1]),
		.ctl_in(ctl_one),
		.count_out(count_one),
		.overflow_out(ovf_one)
	);

	pulse_counter_unit counter_two (
		.core_clk_in(core_clk_in),
		.reset_n_in(reset_n_in),
		.pulse_in(s_r.sync_two[1]),
		.ctl_in(ctl_two),
		.count_out(count_two),
		.overflow_out(ovf_two)
	);

	// ==========================================================
	// Next state
	always_comb begin
		logic [7:0] ctl_v;
		logic [1:0] stat_v;
		logic hit;
		ctl_v = s_r.control;
		stat_v = s_r.irq_status;
		hit = 1'b1;
		s_nxt = s_r;
		// No power-mode input gates anything here: the synchronisers never pause
		s_nxt.sync_one = {s_r.sync_one[0], pulse_input_one_in};
		s_nxt.sync_two = {s_r.sync_two[0], pulse_input_two_in};

		// Bus handshake: one wait cycle, answer, then release
		case (s_r.bus_state)
			BUS_IDLE: begin
				s_nxt.waitrequest = 1'b1;
				if (req.read || req.write) begin
					s_nxt.bus_state = BUS_ANSWER;
					s_nxt.waitrequest = 1'b0;
				end
			end
			BUS_ANSWER: begin
				s_nxt.bus_state = BUS_RELEASE;
				s_nxt.waitrequest = 1'b1;
			end
			BUS_RELEASE: begin
				s_nxt.bus_state = BUS_IDLE;
				s_nxt.waitrequest = 1'b1;
			end
			default: begin
				s_nxt.bus_state = BUS_IDLE;
				s_nxt.waitrequest = 1'b1;
			end
		endcase

		s_nxt.readdata = 32'h0000_0000;
		s_nxt.response = 2'b00;
		if (s_r.bus_state == BUS_IDLE && (req.read || req.write)) begin
			case (req.byte_addr)
				8'(`PC_CONTROL_ADDR): s_nxt.readdata = {24'h000000, s_r.control};
				8'(`PC_CNT1_LO_ADDR): s_nxt.readdata = {24'h000000, count_one[7:0]};
				8'(`PC_CNT1_HI_ADDR): s_nxt.readdata = {24'h000000, count_one[15:8]};
				8'(`PC_CNT2_LO_ADDR): s_nxt.readdata = {24'h000000, count_two[7:0]};
				8'(`PC_CNT2_HI_ADDR): s_nxt.readdata = {24'h000000, count_two[15:8]};
				8'(`PC_IRQ_STATUS_ADDR): s_nxt.readdata = {30'h0, s_r.irq_status};
				8'(`PC_IRQ_MASK_ADDR): s_nxt.readdata = {30'h0, s_r.irq_mask};
				default: hit = 1'b0;
			endcase
			if (!hit) begin
				s_nxt.response = 2'b10;
			end
		end
		// Read data and response stand only in the answer cycle, zero otherwise

		// Software writes to control; unused bits stay zero
		if (wr_lane0 && req.byte_addr == 8'(`PC_CONTROL_ADDR)) begin
			ctl_v = wbyte & `PC_CONTROL_RW_MASK;
		end
		// Hardware sets flags after the write so a set wins over a clear
		if (ovf_one && s_r.control[`PC_BIT_IRQ_EN_ONE]) begin
			ctl_v[`PC_BIT_FLAG_ONE] = 1'b1;
		end
		if (ovf_two && s_r.control[`PC_BIT_IRQ_EN_TWO]) begin
			ctl_v[`PC_BIT_FLAG_TWO] = 1'b1;
		end
		s_nxt.control = ctl_v;

		// Sticky status of overflow events, write one to clear
		if (wr_lane0 && req.byte_addr == 8'(`PC_IRQ_STATUS_ADDR)) begin
			stat_v = stat_v & ~wbyte[1:0];
		end
		if (wr_lane0 && req.byte_addr == 8'(`PC_IRQ_MASK_ADDR)) begin
			s_nxt.irq_mask = wbyte[1:0];
		end
		stat_v = stat_v | {ovf_two, ovf_one};
		s_nxt.irq_status = stat_v;

		// Flag drives line only with its enable bit; line is wired OR
		s_nxt.ext_line = (ctl_v[`PC_BIT_FLAG_ONE] && ctl_v[`PC_BIT_IRQ_EN_ONE])
			|| (ctl_v[`PC_BIT_FLAG_TWO] && ctl_v[`PC_BIT_IRQ_EN_TWO]);
		s_nxt.irq = |(stat_v & s_nxt.irq_mask);
	end

	// ==========================================================
	// Registers
	always_ff @(posedge core_clk_in) begin
		if (!reset_n_in) begin
			s_r <= '{sync_one: 2'h0, sync_two: 2'h0, control: `PC_CONTROL_RESET,
				irq_status: `PC_IRQ_RESET, irq_mask: `PC_IRQ_RESET, bus_state: BUS_IDLE,
				readdata: 32'h0000_0000, response: 2'h0, waitrequest: 1'b1,
				ext_line: 1'b0, irq: 1'b0};
		end else begin
			s_r <= s_nxt;
		end
	end

	assign avs_readdata_out = s_r.readdata;
	assign avs_waitrequest_out = s_r.waitrequest;
	assign avs_response_out = s_r.response;
	assign external_interrupt_line_out = s_r.ext_line;
	assign irq_out = s_r.irq;
endmodule

// ---- tb/pulse_source.sv ----
// Model of the pulse sources on one count input
`timescale 1ns/1ps
module pulse_source (
	input wire logic core_clk_in, // Clock
	input wire logic start_in, // Begin a burst
	input wire logic [7:0] count_in, // Falling edges wanted
	output logic pulse_out, // Count pin, idles high
	output logic busy_out // Burst running
);
	logic [7:0] left_r;
	logic [6:0] ph_r;
	initial begin
		pulse_out = 1'b1;
		busy_out = 1'b0;
		left_r = 8'h00;
		ph_r = 7'h00;
	end
	// ====================
	// 100 cycle period, so never above 1 MHz
	always @(posedge core_clk_in) begin
		if (start_in && !busy_out) begin
			busy_out <= count_in != 8'h00;
			left_r <= count_in;
			ph_r <= 7'h00;
		end else if (busy_out) begin
			ph_r <= (ph_r == 7'h63) ? 7'h00 : ph_r + 7'h01;
			if (ph_r == 7'h31) begin
				pulse_out <= 1'b0;
				left_r <= left_r - 8'h01;
			end
			if (ph_r == 7'h63) begin
				pulse_out <= 1'b1;
				busy_out <= left_r != 8'h00;
			end
		end
	end
endmodule

// ---- tb/dual_pulse_counter_asserts.sv ----
// Checker for the pulse counter bus and interrupt pins
`timescale 1ns/1ps
`include "pulse_counter_map.svh"
module dual_pulse_counter_asserts (
	input wire logic core_clk_in, // Clock
	input wire logic reset_n_in, // Reset
	input wire logic pulse_input_one_in, // Pin one
	input wire logic pulse_input_two_in, // Pin two
	input wire logic [7:0] avs_address_in, // Address
	input wire logic avs_read_in, // Read
	input wire logic avs_write_in, // Write
	input wire logic [31:0] avs_writedata_in, // Write data
	input wire logic [3:0] avs_byteenable_in, // Lanes
	input wire logic [31:0] avs_readdata_out, // Read data
	input wire logic avs_waitrequest_out, // Stall
	input wire logic [1:0] avs_response_out, // Response
	input wire logic external_interrupt_line_out, // Overflow line
	input wire logic irq_out // Masked irq
);
	logic rq;
	logic mapped;
	logic ack;
	assign rq = avs_read_in | avs_write_in;
	assign mapped = avs_address_in >= `PC_CONTROL_IDX && avs_address_in <= `PC_IRQ_MASK_IDX;
	assign ack = !avs_waitrequest_out && avs_byteenable_in[0];
	default clocking @(posedge core_clk_in); endclocking
	default disable iff (!reset_n_in);
	// ====================
	// Bus, reset and interrupt pins
	a_answer_next: assert property ($rose(rq) |=> !avs_waitrequest_out)
		else $error("no answer one cycle after request");
	a_wait_single: assert property (!avs_waitrequest_out |=> avs_waitrequest_out)
		else $error("waitrequest low too long");
	a_wait_idle: assert property (!rq |=> avs_waitrequest_out)
		else $error("waitrequest low without request");
	a_rdata_idle: assert property (avs_waitrequest_out |-> avs_readdata_out == 32'h0)
		else $error("read data outside answer");
	a_err_unmapped: assert property (!avs_waitrequest_out && !mapped |->
		avs_response_out == 2'h2 && (avs_write_in || avs_readdata_out == 32'h0))
		else $error("unmapped access not refused");
	a_okay_mapped: assert property (!avs_waitrequest_out && mapped |-> avs_response_out == 2'h0)
		else $error("mapped access refused");
	a_ctl_zero_bits: assert property (
		!avs_waitrequest_out && avs_read_in && avs_address_in == `PC_CONTROL_IDX |->
		avs_readdata_out[31:8] == 24'h0 && !avs_readdata_out[5] && !avs_readdata_out[1])
		else $error("unused control bits read nonzero");
	a_reset_quiet: assert property (disable iff (1'b0) !reset_n_in |=>
		avs_waitrequest_out && !external_interrupt_line_out && !irq_out)
		else $error("outputs active after reset");
	a_ext_gated: assert property (ack && avs_write_in && avs_address_in == `PC_CONTROL_IDX &&
		!avs_writedata_in[6] && !avs_writedata_in[2] |-> ##2 !external_interrupt_line_out)
		else $error("overflow line high with irq enables clear");
	a_mask_gated: assert property (ack && avs_write_in && avs_address_in == `PC_IRQ_MASK_IDX &&
		avs_writedata_in[1:0] == 2'h0 |-> ##2 !irq_out)
		else $error("irq high with mask clear");
	c_ext: cover property ($rose(external_interrupt_line_out));
	c_irq: cover property ($rose(irq_out));
	c_err: cover property (!avs_waitrequest_out && !mapped);
endmodule
bind dual_pulse_counter dual_pulse_counter_asserts u_chk (.*);

// ---- tb/dual_pulse_counter_tb.sv ----
// Self-checking bench for the dual pulse counter
`timescale 1ns/1ps
`include "pulse_counter_map.svh"
module dual_pulse_counter_tb;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic [7:0] adr_r = 8'h00;
	logic [31:0] wd_r = 32'h0;
	logic rd_r = 1'b0;
	logic wr_r = 1'b0;
	logic [1:0] go_r = 2'h0;
	logic [7:0] n_r = 8'h00;
	logic [1:0] pin;
	logic [1:0] busy;
	logic [31:0] rdat;
	logic [31:0] rd;
	logic [1:0] resp;
	logic [1:0] rsp;
	logic wait_q;
	logic ext;
	logic irq;
	int failures = 0;
	int checked = 0;
	always #5 clk = ~clk;
	dual_pulse_counter u_dut (.core_clk_in(clk), .reset_n_in(rst_n),
		.pulse_input_one_in(pin[0]), .pulse_input_two_in(pin[1]), .avs_address_in(adr_r),
		.avs_read_in(rd_r), .avs_write_in(wr_r), .avs_writedata_in(wd_r),
		.avs_byteenable_in(4'hF), .avs_readdata_out(rdat), .avs_waitrequest_out(wait_q),
		.avs_response_out(resp), .external_interrupt_line_out(ext), .irq_out(irq));
	pulse_source u_src1 (.core_clk_in(clk), .start_in(go_r[0]), .count_in(n_r),
		.pulse_out(pin[0]), .busy_out(busy[0]));
	pulse_source u_src2 (.core_clk_in(clk), .start_in(go_r[1]), .count_in(n_r),
		.pulse_out(pin[1]), .busy_out(busy[1]));
	// ====================
	// Tasks
	task automatic print_verdict();
		$display("checked=%0d failures=%0d", checked, failures);
		if (failures == 0 && checked > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		checked++;
		if (g !== e) begin
			failures++;
			$display("[ERR] %s at %h expected %h seen %h", nm, adr_r, e, g);
		end
	endtask
	task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
		adr_r <= a;
		wd_r <= {24'h0, d};
		wr_r <= w;
		rd_r <= !w;
		@(posedge clk);
		while (wait_q !== 1'b0) @(posedge clk);
		rd = rdat;
		rsp = resp;
		wr_r <= 1'b0;
		rd_r <= 1'b0;
		@(posedge clk);
	endtask
	task automatic rdc(input logic [7:0] a, input logic [7:0] e);
		acc(1'b0, a, 8'h00);
		chk("rdata", {24'h0, e}, rd);
	endtask
	task automatic pul(input int ch, input logic [7:0] n);
		n_r <= n;
		go_r[ch] <= 1'b1;
		@(posedge clk);
		go_r <= 2'h0;
		@(posedge clk);
		while (busy[ch]) @(posedge clk);
		repeat (8) @(posedge clk);
	endtask
	task automatic lines(input logic e, input logic i);
		repeat (3) @(posedge clk);
		chk("ext line", {31'h0, e}, {31'h0, ext});
		chk("irq", {31'h0, i}, {31'h0, irq});
	endtask
	// ====================
	// Tests
	initial begin
		repeat (20000) @(posedge clk);
		failures++;
		print_verdict();
	end
	initial begin
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		for (logic [7:0] a = 8'h40; a < 8'h47; a++) rdc(a, 8'h00);
		acc(1'b0, 8'h00, 8'h00);
		chk("unmapped response", 32'h2, {30'h0, rsp});
		acc(1'b1, `PC_CONTROL_IDX, 8'hFF);
		rdc(`PC_CONTROL_IDX, 8'hDD);
		acc(1'b1, `PC_CONTROL_IDX, 8'h00);
		rdc(`PC_CONTROL_IDX, 8'h00);
		acc(1'b1, `PC_IRQ_MASK_IDX, 8'h03);
		acc(1'b1, `PC_CONTROL_IDX, 8'h80);
		pul(0, 8'h03);
		pul(1, 8'h02);
		rdc(`PC_CNT1_LO_IDX, 8'h03);
		rdc(`PC_CNT2_LO_IDX, 8'h00);
		acc(1'b1, `PC_CONTROL_IDX, 8'h00);
		pul(0, 8'h02);
		rdc(`PC_CNT1_LO_IDX, 8'h03);
		acc(1'b1, `PC_CNT1_LO_IDX, 8'hFE);
		acc(1'b1, `PC_CNT1_HI_IDX, 8'hFF);
		rdc(`PC_CNT1_HI_IDX, 8'hFF);
		acc(1'b1, `PC_CONTROL_IDX, 8'hC0);
		pul(0, 8'h03);
		rdc(`PC_CNT1_LO_IDX, 8'h01);
		rdc(`PC_CNT1_HI_IDX, 8'h00);
		rdc(`PC_CONTROL_IDX, 8'hD0);
		rdc(`PC_IRQ_STATUS_IDX, 8'h01);
		lines(1'b1, 1'b1);
		acc(1'b1, `PC_IRQ_MASK_IDX, 8'h00);
		lines(1'b1, 1'b0);
		acc(1'b1, `PC_IRQ_MASK_IDX, 8'h03);
		lines(1'b1, 1'b1);
		acc(1'b1, `PC_IRQ_STATUS_IDX, 8'h01);
		lines(1'b1, 1'b0);
		acc(1'b1, `PC_CONTROL_IDX, 8'h40);
		lines(1'b0, 1'b0);
		// Counter two is still at its reset zero, so its wrap is disarmed
		acc(1'b1, `PC_CNT2_LO_IDX, 8'hFF);
		acc(1'b1, `PC_CNT2_HI_IDX, 8'hFF);
		acc(1'b1, `PC_CONTROL_IDX, 8'h0C);
		pul(1, 8'h01);
		rdc(`PC_CNT2_HI_IDX, 8'h00);
		rdc(`PC_CONTROL_IDX, 8'h0C);
		rdc(`PC_IRQ_STATUS_IDX, 8'h00);
		acc(1'b1, `PC_IRQ_STATUS_IDX, 8'h02);
		acc(1'b1, `PC_CONTROL_IDX, 8'h01);
		lines(1'b0, 1'b0);
		acc(1'b1, `PC_CONTROL_IDX, 8'h05);
		lines(1'b1, 1'b0);
		print_verdict();
	end
endmodule
